/* File: rtl/flash_cmd_cfg.svh */
// Constants for the flash command sequencer host controller
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH
// Device command codes
`define CMD_READ_ARRAY   8'hFF
`define CMD_READ_STATUS  8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_SUSPEND      8'hB0
`define CMD_RESUME       8'hD0
`define CMD_PROTECT_SET  8'h60
`define CMD_PROTECT_CONF 8'h01
`define CMD_UNPROT_CONF  8'hD0
`define CMD_OTP_SETUP    8'hC0
`define CMD_PIN_SETUP    8'hB8
// Status bit positions
`define ST_IDLE_BIT      7
`define ST_ERASE_PS_BIT  6
`define ST_ERR_HI_BIT    5
`define ST_ERR_LO_BIT    3
`define ST_PROG_PS_BIT   2
// Wishbone register offsets (byte addresses)
`define REG_CTRL         4'h0
`define REG_ADDR         4'h4
`define REG_DATA         4'h8
`define REG_STAT         4'hC
// Control fields
`define CTRL_OP_LSB      0
`define CTRL_GO_BIT      4
// Bus timing in ns at the 100 ns core clock
`define CLK_PERIOD_NS    100
`define WR_PULSE_NS      100
`define RD_ACCESS_NS     200
`define WR_PULSE_CYC  (((`WR_PULSE_NS)+(`CLK_PERIOD_NS)-1)/(`CLK_PERIOD_NS))
`define RD_ACCESS_CYC (((`RD_ACCESS_NS)+(`CLK_PERIOD_NS)-1)/(`CLK_PERIOD_NS))
`define ST_RESET         8'h80
`endif

/* File: rtl/flash_cmd_pkg.sv */
// Types for the flash command sequencer host controller
package flash_cmd_pkg;
   typedef enum logic [3:0] {
      OP_SUSPEND, OP_RESUME, OP_PROTECT, OP_UNPROTECT_ALL,
      OP_OTP_PROGRAM, OP_PIN_CONFIG, OP_READ_STATUS,
      OP_CLEAR_STATUS, OP_READ_ARRAY, OP_READ_WORD
   } op_t;
   typedef struct packed {
      logic [22:0] addr;
      logic [15:0] dout;
      logic        we_n;
      logic        oe_n;
      logic        ce_n;
      logic        dq_oe_n;
   } flash_bus_t;
endpackage : flash_cmd_pkg

/* File: rtl/flash_bus_cycle.sv */
// One asynchronous bus write or read cycle toward the flash
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_cfg.svh"
module flash_bus_cycle (
   // Clock and reset
   input  wire logic                      i_core_clk,
   input  wire logic                      i_rst_n,
   // Request
   input  wire logic                      i_start,
   input  wire logic                      i_write,
   input  wire logic [22:0]               i_addr,
   input  wire logic [15:0]               i_wdata,
   output logic                           o_done,
   output logic [15:0]                    o_rdata,
   // Flash pins
   output flash_cmd_pkg::flash_bus_t      o_bus,
   input  wire logic [15:0]               i_dq
);
   import flash_cmd_pkg::*;
   // ==========================================================
   // Pin synchroniser
   logic [15:0] dq_s1_reg;
   logic [15:0] dq_s2_reg;
   always_ff @(posedge i_core_clk) begin
      dq_s1_reg <= i_dq;
      dq_s2_reg <= dq_s1_reg;
   end
   // ==========================================================
   // Cycle timer; read waits access time plus synchroniser
   logic [3:0] cnt_reg;
   logic       busy_reg;
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         busy_reg <= 1'b0;
         cnt_reg  <= 4'h0;
         o_done   <= 1'b0;
         o_rdata  <= 16'h0000;
         o_bus    <= '{addr: 23'h0, dout: 16'h0, we_n: 1'b1,
                       oe_n: 1'b1, ce_n: 1'b1, dq_oe_n: 1'b1};
      end else begin
         o_done <= 1'b0;
         if (!busy_reg && i_start) begin
            busy_reg      <= 1'b1;
            cnt_reg       <= i_write ? 4'(`WR_PULSE_CYC)
                                     : 4'(`RD_ACCESS_CYC + 2);
            o_bus.addr    <= i_addr;
            o_bus.dout    <= i_wdata;
            o_bus.ce_n    <= 1'b0;
            o_bus.we_n    <= !i_write;
            o_bus.oe_n    <= i_write;
            o_bus.dq_oe_n <= !i_write;
         end else if (busy_reg) begin
            if (cnt_reg != 4'h0) begin
               cnt_reg <= cnt_reg - 4'h1;
            end else begin
               busy_reg      <= 1'b0;
               o_done        <= 1'b1;
               o_rdata       <= dq_s2_reg;
               o_bus.we_n    <= 1'b1;
               o_bus.oe_n    <= 1'b1;
               o_bus.ce_n    <= 1'b1;
               o_bus.dq_oe_n <= 1'b1;
            end
         end
      end
   end
endmodule : flash_bus_cycle
`default_nettype wire

/* File: rtl/flash_cmd_host.sv */
// Host controller issuing suspend, protect, OTP and pin commands
//
// Contract
// [R01] After suspend, idle flag then pause flags decide
// [R02] Suspended device takes only read and resume; the code still issues suspend and clear status
// [R03] Erase suspend also allows buffered program
// [R04] Return to read array before resuming erase
// [R05] Avoid the block under erase suspend
// [R06] Resume code restarts controller, reads give status
// [R07] Protect: setup then confirm in target block
// [R08] During protect only status read accepted
// [R09] Protection flags persist; only unprotect-all clears
// [R10] Unprotect-all: setup then confirm, any address
// [R11] During unprotect-all only status read accepted
// [R12] OTP program: setup then address and data
// [R13] Lock bit 1 user, bit 0 factory
// [R14] Locked OTP write leaves data, flags error
// [R15] OTP program cannot be suspended
// [R16] Pin in level ready/busy after reset
// [R17] Pin config: setup then one of four codes
// [R18] Pin config refused while busy or suspended
// [R19] Pulse modes give about 250ns low
// [R20] Invalid pin code flags status error
// [R21] After suspend wait for idle before commands
// [R22] Codes: 0 level, 1 erase, 2 program, 3 both
// [R23] Level mode low while busy, released when ready
// [R24] Clear status after an error before new work; the code still accepts pin config
// [R25] Two-write sequences tracked in a state machine
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_cfg.svh"
module flash_cmd_host (
   // Clock and reset
   input  wire logic                      i_core_clk,
   input  wire logic                      i_rst_n,
   // Wishbone slave
   input  wire logic                      i_wb_cyc,
   input  wire logic                      i_wb_stb,
   input  wire logic                      i_wb_we,
   input  wire logic [3:0]                i_wb_adr,
   input  wire logic [3:0]                i_wb_sel,
   input  wire logic [31:0]               i_wb_dat,
   output logic [31:0]                    o_wb_dat,
   output logic                           o_wb_ack,
   // Flash pins
   output flash_cmd_pkg::flash_bus_t      o_flash,
   input  wire logic [15:0]               i_dq,
   input  wire logic                      i_status_ready_output
);
   import flash_cmd_pkg::*;

   // ==========================================================
   // Registers
   op_t         op_reg;
   logic [22:0] addr_reg;
   logic [15:0] data_reg;
   logic [7:0]  status_readback_value_reg;
   logic [15:0] rdata_reg;
   logic        busy_reg;
   logic        err_reg;
   logic        suspended_reg;
   logic        erase_susp_reg;
   logic        refused_reg;
   logic [1:0]  pin_mode_reg;
   logic        rdy_s1_reg;
   logic        rdy_s2_reg;
   logic        start_reg;
   logic        write_reg;
   logic [22:0] cyc_addr_reg;
   logic [15:0] cyc_data_reg;
   logic        cyc_done;
   logic [15:0] cyc_rdata;

   typedef enum logic [2:0] {
      S_IDLE, S_FIRST, S_SECOND, S_POLL, S_WAIT, S_DONE
   } seq_t;
   seq_t state_reg;

   function automatic logic two_write(input op_t op);
      return op == OP_PROTECT || op == OP_UNPROTECT_ALL ||
             op == OP_OTP_PROGRAM || op == OP_PIN_CONFIG;
   endfunction : two_write

   function automatic logic [7:0] first_code(input op_t op);
      unique case (op)
         OP_SUSPEND:       return `CMD_SUSPEND;
         OP_RESUME:        return `CMD_RESUME;
         OP_PROTECT:       return `CMD_PROTECT_SET;
         OP_UNPROTECT_ALL: return `CMD_PROTECT_SET;
         OP_OTP_PROGRAM:   return `CMD_OTP_SETUP;
         OP_PIN_CONFIG:    return `CMD_PIN_SETUP;
         OP_READ_STATUS:   return `CMD_READ_STATUS;
         OP_CLEAR_STATUS:  return `CMD_CLEAR_STATUS;
         default:          return `CMD_READ_ARRAY;
      endcase
   endfunction : first_code

   // ==========================================================
   // Ready pin synchroniser
   always_ff @(posedge i_core_clk) begin
      rdy_s1_reg <= i_status_ready_output;
      rdy_s2_reg <= rdy_s1_reg;
   end

   // ==========================================================
   // Bus cycle engine
   flash_bus_cycle u_cycle (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_start    (start_reg),
      .i_write    (write_reg),
      .i_addr     (cyc_addr_reg),
      .i_wdata    (cyc_data_reg),
      .o_done     (cyc_done),
      .o_rdata    (cyc_rdata),
      .o_bus      (o_flash),
      .i_dq       (i_dq)
   );

   // ==========================================================
   // Go decision: refuse orders the device would reject
   logic go_req;
   logic go_ok;
   assign go_req = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack &&
                   i_wb_adr == `REG_CTRL && i_wb_sel[0] &&
                   i_wb_dat[`CTRL_GO_BIT];
   op_t go_op;
   assign go_op = op_t'(i_wb_dat[`CTRL_OP_LSB +: 4]);
   always_comb begin
      go_ok = state_reg == S_IDLE;
      // Pin config is refused while busy or paused [R18]
      if (go_op == OP_PIN_CONFIG && suspended_reg)
         go_ok = 1'b0;
      // After an error, resume and two-write work other than pin config need clear status first [R24]
      if (err_reg && (go_op == OP_RESUME || two_write(go_op)) &&
          go_op != OP_PIN_CONFIG)
         go_ok = 1'b0;
      // Paused device gets no two-write command; suspend and clear status still go through [R02] [R03]
      if (suspended_reg && two_write(go_op))
         go_ok = 1'b0;
      // Resume after an array read [R04]; go bit 8 flags paused block
      if (erase_susp_reg && go_op == OP_RESUME && op_reg != OP_READ_ARRAY)
         go_ok = 1'b0;
      if (erase_susp_reg && go_op == OP_READ_WORD && i_wb_dat[8]) // [R05]
         go_ok = 1'b0;
   end

   // ==========================================================
   // Sequencer: setup write, second write, then status poll [R25]
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_reg    <= S_IDLE;
         start_reg    <= 1'b0;
         write_reg    <= 1'b0;
         cyc_addr_reg <= 23'h0;
         cyc_data_reg <= 16'h0;
         op_reg       <= OP_READ_STATUS;
         refused_reg  <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         if (go_req)
            refused_reg <= !go_ok;
         unique case (state_reg)
            S_IDLE: if (go_req) begin
               if (go_ok) begin
                  op_reg       <= go_op;
                  state_reg    <= S_FIRST;
                  start_reg    <= 1'b1;
                  write_reg    <= 1'b1;
                  cyc_addr_reg <= addr_reg;
                  cyc_data_reg <= {8'h00, first_code(go_op)};
               end
            end
            S_FIRST: if (cyc_done) begin
               start_reg <= 1'b1;
               if (two_write(op_reg)) begin
                  // Confirm lands inside the target block [R07] [R10]
                  state_reg    <= S_SECOND;
                  write_reg    <= 1'b1;
                  cyc_data_reg <= op_reg == OP_PROTECT ?
                                  16'(`CMD_PROTECT_CONF) :
                                  op_reg == OP_UNPROTECT_ALL ?
                                  16'(`CMD_UNPROT_CONF) :
                                  data_reg; // [R12] [R17] [R22]
               end else if (op_reg == OP_READ_WORD) begin
                  state_reg <= S_WAIT;
                  write_reg <= 1'b0;
               end else begin
                  // Suspend/resume then poll until idle [R21] [R06]
                  state_reg <= S_POLL;
                  write_reg <= 1'b0;
               end
            end
            S_SECOND: if (cyc_done) begin
               // Only status reads while the operation runs [R08] [R11]
               state_reg <= S_POLL;
               start_reg <= 1'b1;
               write_reg <= 1'b0;
            end
            S_POLL: if (cyc_done) begin
               if (cyc_rdata[`ST_IDLE_BIT] ||
                   op_reg == OP_READ_ARRAY ||
                   op_reg == OP_CLEAR_STATUS) begin
                  state_reg <= S_DONE;
               end else begin
                  start_reg <= 1'b1;
               end
            end
            S_WAIT: if (cyc_done)
               state_reg <= S_DONE;
            S_DONE: state_reg <= S_IDLE;
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Device status tracking
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         status_readback_value_reg <= `ST_RESET;
         rdata_reg      <= 16'h0000;
         suspended_reg  <= 1'b0;
         erase_susp_reg <= 1'b0;
         err_reg        <= 1'b0;
         busy_reg       <= 1'b0;
      end else begin
         busy_reg <= state_reg != S_IDLE && state_reg != S_DONE;
         if (state_reg == S_WAIT && cyc_done)
            rdata_reg <= cyc_rdata;
         if (state_reg == S_POLL && cyc_done) begin
            status_readback_value_reg <= cyc_rdata[7:0];
            if (cyc_rdata[`ST_IDLE_BIT]) begin
               // Pause flags tell suspended from finished [R01]
               suspended_reg  <= cyc_rdata[`ST_PROG_PS_BIT] ||
                                 cyc_rdata[`ST_ERASE_PS_BIT];
               erase_susp_reg <= cyc_rdata[`ST_ERASE_PS_BIT];
               // Locked OTP or bad pin code shows here [R14] [R20]
               err_reg <= |cyc_rdata[`ST_ERR_HI_BIT:`ST_ERR_LO_BIT];
            end
         end
         if (state_reg == S_DONE && op_reg == OP_CLEAR_STATUS)
            err_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Wishbone slave, answer one cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         addr_reg     <= 23'h0;
         data_reg     <= 16'h0;
         pin_mode_reg <= 2'h0; // [R16]
         o_wb_ack     <= 1'b0;
         o_wb_dat     <= 32'h0;
      end else begin
         o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
         if (state_reg == S_DONE && op_reg == OP_PIN_CONFIG &&
             !err_reg)
            pin_mode_reg <= data_reg[1:0];
         if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
            if (i_wb_we) begin
               if (i_wb_adr == `REG_ADDR)
                  addr_reg <= i_wb_dat[22:0];
               if (i_wb_adr == `REG_DATA)
                  data_reg <= i_wb_dat[15:0];
               o_wb_dat <= 32'h0;
            end else begin
               unique case (i_wb_adr)
                  `REG_CTRL: o_wb_dat <= {27'h0, refused_reg, op_reg};
                  `REG_ADDR: o_wb_dat <= {9'h0, addr_reg};
                  `REG_DATA: o_wb_dat <= {16'h0, rdata_reg};
                  `REG_STAT: o_wb_dat <= {17'h0, pin_mode_reg,
                                 rdy_s2_reg, erase_susp_reg,
                                 suspended_reg, err_reg, busy_reg,
                                 status_readback_value_reg};
                  default:   o_wb_dat <= 32'h0;
               endcase
            end
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   property p_ack_one;
      o_wb_ack |=> !o_wb_ack;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack held");
   property p_two_write_second;
      (state_reg == S_FIRST && cyc_done && two_write(op_reg)) |=>
      state_reg == S_SECOND && start_reg && write_reg;
   endproperty
   a_two_write_second: assert property (p_two_write_second) // [R25]
      else $error("second write missing");
   property p_poll_read;
      (state_reg == S_SECOND && cyc_done) |=>
      state_reg == S_POLL && !write_reg;
   endproperty
   a_poll_read: assert property (p_poll_read) // [R08]
      else $error("no status poll");
   property p_pin_refused;
      (go_req && go_op == OP_PIN_CONFIG &&
       (suspended_reg || state_reg != S_IDLE)) |=>
      refused_reg && $stable(op_reg);
   endproperty
   a_pin_refused: assert property (p_pin_refused) // [R18]
      else $error("pin config not refused");
   property p_susp_block;
      (go_req && two_write(go_op) &&
       (suspended_reg || state_reg != S_IDLE)) |=>
      refused_reg && $stable(op_reg);
   endproperty
   a_susp_block: assert property (p_susp_block) // [R02]
      else $error("command while paused");
   property p_err_block;
      (go_req && err_reg && go_op == OP_RESUME) |=> refused_reg;
   endproperty
   a_err_block: assert property (p_err_block) // [R24]
      else $error("work after error");
   property p_poll_idle;
      (state_reg == S_POLL && cyc_done && !cyc_rdata[`ST_IDLE_BIT] &&
       (op_reg == OP_SUSPEND || two_write(op_reg))) |=>
      state_reg == S_POLL && start_reg;
   endproperty
   a_poll_idle: assert property (p_poll_idle) // [R21]
      else $error("poll stopped early");
   property p_confirm_code;
      (state_reg == S_FIRST && cyc_done && op_reg == OP_PROTECT) |=>
      cyc_data_reg == 16'(`CMD_PROTECT_CONF);
   endproperty
   a_confirm_code: assert property (p_confirm_code) // [R07]
      else $error("bad confirm");
   c_protect: cover property (state_reg == S_DONE && op_reg == OP_PROTECT);
   c_suspend: cover property (suspended_reg);
   c_pin: cover property (state_reg == S_DONE && op_reg == OP_PIN_CONFIG);
endmodule : flash_cmd_host
`default_nettype wire

/* File: tb/flash_dev_model.sv */
// Behavioural flash device that answers the host controller's bus cycles
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
   parameter int BUSY_NS = 3000
) (
   // Flash pins
   input  wire flash_cmd_pkg::flash_bus_t i_flash,
   output logic [15:0]                    o_dq,
   output logic                           o_sts
);
   import flash_cmd_pkg::*;
   // ==========================================================
   // State, no reset pin: protection survives controller reset
   logic [15:0] otp_reg [0:8];
   logic [63:0] prot_reg  = '0;
   logic [1:0]  lock_reg  = 2'b10;
   logic [1:0]  pin_mode  = 2'b00;
   logic [7:0]  setup_reg = 8'h00;
   logic        busy      = 1'b0;
   logic        stat_mode = 1'b0;
   logic        err_flag  = 1'b0;
   logic        pulse     = 1'b0;
   logic [15:0] last_dq   = 16'h0000;
   logic [15:0] rd_val;
   logic        wr_act;
   logic [7:0]  cmd;
   logic [7:0]  idx;
   initial begin
      for (int i = 0; i < 9; i++) begin
         otp_reg[i] = 16'hFFFF;
      end
   end
   // ==========================================================
   // Command decode, taken as the write strobe ends
   assign wr_act = !i_flash.we_n && !i_flash.ce_n;
   always @(negedge wr_act) begin
      cmd = i_flash.dout[7:0];
      idx = i_flash.addr[7:0] - 8'h80;
      if (busy) begin
         if (cmd == 8'h70) stat_mode = 1'b1;
      end else if (setup_reg != 8'h00) begin
         if (setup_reg == 8'h60 && cmd == 8'h01) begin
            prot_reg[i_flash.addr[22:17]] = 1'b1;
            busy = 1'b1;
         end else if (setup_reg == 8'h60 && cmd == 8'hD0) begin
            prot_reg = '0;
            busy = 1'b1;
         end else if (setup_reg == 8'hC0) begin
            // Flash cells only clear bits, so locks cannot be undone
            if (idx == 8'h00) lock_reg = lock_reg & i_flash.dout[1:0];
            else if (idx > 4 && idx < 9 && lock_reg[1])
               otp_reg[idx] = otp_reg[idx] & i_flash.dout;
            else err_flag = 1'b1;
            busy = 1'b1;
         end else if (setup_reg == 8'hB8) begin
            if (cmd < 8'h04) pin_mode = cmd[1:0];
            else err_flag = 1'b1;
         end
         setup_reg = 8'h00;
      end else begin
         case (cmd)
            8'hFF: stat_mode = 1'b0;
            8'h70, 8'hD0: stat_mode = 1'b1;
            8'h50: err_flag = 1'b0;
            8'h60, 8'hC0, 8'hB8: begin
               setup_reg = cmd;
               stat_mode = 1'b1;
            end
            default: ;
         endcase
      end
   end
   // ==========================================================
   // Operation timer and completion pulse
   always @(posedge busy) begin
      #(BUSY_NS);
      busy = 1'b0;
      if (pin_mode[1]) begin
         pulse = 1'b1;
         #250;
         pulse = 1'b0;
      end
   end
   // ==========================================================
   // Read path; a released bus shows the inverse of the last word
   assign rd_val = stat_mode ? {8'h00, !busy, 2'b00, err_flag, 4'h0}
                             : (i_flash.addr[15:0] ^ 16'h5A5A);
   always @(posedge i_flash.oe_n) last_dq = rd_val;
   assign o_dq = (!i_flash.ce_n && !i_flash.oe_n && i_flash.dq_oe_n)
                 ? rd_val : ~last_dq;
   // Open drain with pull-up: released reads high
   assign o_sts = (pin_mode == 2'b00) ? !busy : !pulse;
endmodule : flash_dev_model
`default_nettype wire

/* File: tb/tb_flash_cmd_host.sv */
// Self-checking bench for the flash command host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_cfg.svh"
module tb_flash_cmd_host;
   import flash_cmd_pkg::*;
   // ==========================================================
   // Signals
   logic        i_core_clk = 1'b0;
   logic        i_rst_n    = 1'b0;
   logic        wb_cyc     = 1'b0;
   logic        wb_stb     = 1'b0;
   logic        wb_we      = 1'b0;
   logic [3:0]  wb_adr     = 4'h0;
   logic [3:0]  wb_sel     = 4'h0;
   logic [31:0] wb_wdat    = 32'h0;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   flash_bus_t  flash_bus;
   logic [15:0] dq;
   logic        sts;
   int          fail_count  = 0;
   int          check_count = 0;
   int          cycles      = 0;
   always #50 i_core_clk = ~i_core_clk;
   flash_cmd_host DUT (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
      .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat),
      .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
      .o_flash(flash_bus), .i_dq(dq), .i_status_ready_output(sts)
   );
   flash_dev_model #(.BUSY_NS(3000)) u_flash (
      .i_flash(flash_bus), .o_dq(dq), .o_sts(sts)
   );
   // ==========================================================
   // Shared tasks
   task print_verdict();
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("[FAIL] run time expected below 20000 seen 20000");
         print_verdict();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic do_reset();
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
   endtask : do_reset
   // Classic single cycle, held until ack is sampled high
   task automatic wb_cycle(input logic w, input logic [3:0] a,
                           input logic [31:0] d, output logic [31:0] q);
      @(posedge i_core_clk);
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= w;
      wb_adr  <= a;
      wb_sel  <= 4'hF;
      wb_wdat <= d;
      @(posedge i_core_clk);
      while (wb_ack !== 1'b1) @(posedge i_core_clk);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
   endtask : wb_cycle
   task automatic go(input op_t op, input logic [31:0] a,
                     input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, `REG_ADDR, a, q);
      wb_cycle(1'b1, `REG_DATA, d, q);
      wb_cycle(1'b1, `REG_CTRL, {27'h0, 1'b1, op}, q);
   endtask : go
   // Poll status until the controller reports not busy
   task automatic run_op(input op_t op, input logic [31:0] a,
                         input logic [31:0] d, output logic [31:0] s);
      int n;
      n = 0;
      go(op, a, d);
      do begin
         wb_cycle(1'b0, `REG_STAT, 32'h0, s);
         n++;
      end while (s[8] !== 1'b0 && n < 200);
      chk("busy after op", 32'h0, {31'h0, s[8]});
   endtask : run_op
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      logic [31:0] s;
      wb_cycle(1'b0, `REG_STAT, 32'h0, s);
      chk("pin mode after reset", 32'h0, {30'h0, s[14:13]});
      chk("ready pin idle", 32'h1, {31'h0, s[12]});
   endtask : t_reset
   task automatic t_protect();
      logic [31:0] s;
      run_op(OP_PROTECT, 32'h0004_0123, 32'h0, s);
      chk("protect idle flag", 32'h1, {31'h0, s[`ST_IDLE_BIT]});
      chk("block 2 protected", 32'h1, {31'h0, u_flash.prot_reg[2]});
      chk("other block free", 32'h0, {31'h0, u_flash.prot_reg[3]});
      do_reset();
      chk("protect kept", 32'h1, {31'h0, u_flash.prot_reg[2]});
      run_op(OP_UNPROTECT_ALL, 32'h0000_0777, 32'h0, s);
      chk("all unprotected", 32'h0, u_flash.prot_reg[31:0]);
      chk("unprotect idle", 32'h1, {31'h0, s[`ST_IDLE_BIT]});
   endtask : t_protect
   task automatic t_pin();
      logic [31:0] s;
      logic [1:0]  codes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      foreach (codes[i]) begin
         run_op(OP_PIN_CONFIG, 32'h0, {30'h0, codes[i]}, s);
         chk("pin mode", {30'h0, codes[i]}, {30'h0, s[14:13]});
      end
      run_op(OP_PIN_CONFIG, 32'h0, 32'h5, s);
      chk("bad code error", 32'h1, {31'h0, s[9]});
      chk("bad code mode kept", 32'h0, {30'h0, s[14:13]});
      run_op(OP_CLEAR_STATUS, 32'h0, 32'h0, s);
      chk("error cleared", 32'h0, {31'h0, s[9]});
   endtask : t_pin
   task automatic t_busy();
      logic [31:0] s;
      go(OP_OTP_PROGRAM, 32'h87, 32'h00FF);
      repeat (10) @(posedge i_core_clk);
      wb_cycle(1'b0, `REG_STAT, 32'h0, s);
      chk("busy mid op", 32'h1, {31'h0, s[8]});
      chk("level pin low busy", 32'h0, {31'h0, s[12]});
      go(OP_SUSPEND, 32'h0, 32'h0);
      go(OP_PIN_CONFIG, 32'h0, 32'h3);
      wb_cycle(1'b0, `REG_CTRL, 32'h0, s);
      chk("config refused flag", 32'h1, {31'h0, s[4]});
      run_op(OP_READ_STATUS, 32'h0, 32'h0, s);
      chk("not suspended", 32'h0, {31'h0, s[10]});
      chk("config refused", 32'h0, {30'h0, s[14:13]});
      chk("otp completed", 32'h00FF, {16'h0, u_flash.otp_reg[7]});
      chk("ready pin after", 32'h1, {31'h0, s[12]});
   endtask : t_busy
   task automatic t_otp();
      logic [31:0] s;
      run_op(OP_OTP_PROGRAM, 32'h85, 32'h1234, s);
      chk("user word", 32'h1234, {16'h0, u_flash.otp_reg[5]});
      chk("no error", 32'h0, {31'h0, s[9]});
      run_op(OP_OTP_PROGRAM, 32'h82, 32'h0000, s);
      chk("factory locked", 32'h1, {31'h0, s[9]});
      chk("factory kept", 32'hFFFF, {16'h0, u_flash.otp_reg[2]});
      run_op(OP_CLEAR_STATUS, 32'h0, 32'h0, s);
      run_op(OP_OTP_PROGRAM, 32'h80, 32'hFFFD, s);
      chk("lock bits", 32'h0, {30'h0, u_flash.lock_reg});
      run_op(OP_OTP_PROGRAM, 32'h86, 32'h0000, s);
      chk("locked write error", 32'h1, {31'h0, s[9]});
      chk("locked word kept", 32'hFFFF, {16'h0, u_flash.otp_reg[6]});
      go(OP_RESUME, 32'h0, 32'h0);
      wb_cycle(1'b0, `REG_CTRL, 32'h0, s);
      chk("resume refused", 32'h1, {31'h0, s[4]});
      run_op(OP_CLEAR_STATUS, 32'h0, 32'h0, s);
      chk("cleared again", 32'h0, {31'h0, s[9]});
   endtask : t_otp
   task automatic t_read();
      logic [31:0] s;
      run_op(OP_READ_WORD, 32'h1234, 32'h0, s);
      wb_cycle(1'b0, `REG_DATA, 32'h0, s);
      chk("array word", 32'h486E, s);
   endtask : t_read
   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      t_reset();
      t_protect();
      t_pin();
      t_busy();
      t_otp();
      t_read();
      print_verdict();
   end
endmodule : tb_flash_cmd_host
`default_nettype wire
